// [psc_pkg.sv]
// Package with the constants of the synthesizer configuration logic.
package psc_pkg;
  localparam int unsigned LOOP_W    = 9;
  localparam int unsigned ODIV_W    = 2;
  localparam int unsigned DIAG_W    = 3;
  localparam int unsigned SHIFT_W   = DIAG_W + ODIV_W + LOOP_W;
  localparam int unsigned LOOP_LSB  = 0;
  localparam int unsigned ODIV_LSB  = LOOP_W;
  localparam int unsigned DIAG_LSB  = LOOP_W + ODIV_W;
  localparam int unsigned SYNC_W    = 3;
  localparam int unsigned ODIV_CNT_W = 3;
  localparam logic [1:0] ODIV_BY2   = 2'h0;
  localparam logic [1:0] ODIV_BY4   = 2'h1;
  localparam logic [1:0] ODIV_BY8   = 2'h2;
  localparam logic [1:0] ODIV_BY1   = 2'h3;
  localparam logic [2:0] CNT_MAX_2  = 3'h0;
  localparam logic [2:0] CNT_MAX_4  = 3'h1;
  localparam logic [2:0] CNT_MAX_8  = 3'h3;
  localparam logic [2:0] CNT_ZERO   = 3'h0;
  localparam logic [LOOP_W-1:0] LOOP_RESET = 9'h1ff;
  localparam logic [ODIV_W-1:0] ODIV_RESET = 2'h3;
  localparam logic [DIAG_W-1:0] DIAG_RESET = 3'h0;
  localparam real OSC_MIN_MHZ = 400.0;
  localparam real OSC_MAX_MHZ = 800.0;
  localparam real REF_CLK_MHZ = 20.0;
endpackage

// [psc_sync.sv]
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ns
module psc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  input  wire logic pinIn,
  output logic      pinOut
);
  typedef struct packed {
    logic [psc_pkg::SYNC_W-1:0] stage;
    logic                       level;
  } psc_sync_type;

  psc_sync_type st_reg;
  psc_sync_type st_next;

  // The first stage only feeds the second; a change counts once stages two and three agree.
  always_comb
  begin
    st_next = st_reg;
    st_next.stage = {st_reg.stage[1:0], pinIn};
    if (st_reg.stage[1] == st_reg.stage[2])
    begin
      st_next.level = st_reg.stage[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= {{psc_pkg::SYNC_W{RESET_VAL}}, RESET_VAL};
    end
    else if (clkEn)
    begin
      st_reg <= st_next;
    end
  end

  assign pinOut = st_reg.level;
endmodule

// [psc_config.sv]
// Configuration logic of the clock synthesizer: loading, divider, gate and selection.
`timescale 1ns/1ns
module psc_config (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  input  wire logic                         clkEn,
  input  wire logic                         serialClkIn,
  input  wire logic                         serialDataIn,
  input  wire logic                         serialLoadIn,
  input  wire logic                         parLoadBIn,
  input  wire logic [psc_pkg::LOOP_W-1:0]   loopDivIn,
  input  wire logic [psc_pkg::ODIV_W-1:0]   outDivIn,
  input  wire logic                         outGateIn,
  input  wire logic                         ref_source_select,
  input  wire logic                         xtalRefIn,
  input  wire logic                         external_ref_in,
  input  wire logic                         oscClkIn,
  output logic [psc_pkg::LOOP_W-1:0]        loopDivOut,
  output logic [psc_pkg::ODIV_W-1:0]        outDivOut,
  output logic [psc_pkg::DIAG_W-1:0]        diagSelOut,
  output logic                              pllRefOut,
  output logic                              synthClkOut,
  output logic                              diagOut
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; reset values mirror the open-pin levels.

  localparam int unsigned NPIN = 9 + psc_pkg::LOOP_W + psc_pkg::ODIV_W;
  localparam logic [NPIN-1:0] PIN_RESET =
    {3'h0, 1'h1, {psc_pkg::LOOP_W{1'b1}}, {psc_pkg::ODIV_W{1'b1}}, 1'h1, 1'h1, 1'h0, 1'h0,
     1'h0};

  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinSyn;

  assign pinRaw = {serialClkIn, serialDataIn, serialLoadIn, parLoadBIn, loopDivIn, outDivIn,
                   outGateIn, ref_source_select, xtalRefIn, external_ref_in, oscClkIn};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      psc_sync #(
        .RESET_VAL (PIN_RESET[gi])
      ) u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clkEn   (clkEn),
        .pinIn   (pinRaw[gi]),
        .pinOut  (pinSyn[gi])
      );
    end
  endgenerate

  logic                       sClk;
  logic                       sData;
  logic                       sLoad;
  logic                       pLoadB;
  logic [psc_pkg::LOOP_W-1:0] pLoop;
  logic [psc_pkg::ODIV_W-1:0] pDiv;
  logic                       gateIn;
  logic                       srcSel;
  logic                       xtalIn;
  logic                       extIn;
  logic                       oscIn;

  assign {sClk, sData, sLoad, pLoadB, pLoop, pDiv, gateIn, srcSel, xtalIn, extIn, oscIn} =
    pinSyn;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding used by the divider and its assertion.

  function automatic logic [2:0] divLimit(input logic [psc_pkg::ODIV_W-1:0] code);
    case (code)
      psc_pkg::ODIV_BY2: divLimit = psc_pkg::CNT_MAX_2;
      psc_pkg::ODIV_BY4: divLimit = psc_pkg::CNT_MAX_4;
      psc_pkg::ODIV_BY8: divLimit = psc_pkg::CNT_MAX_8;
      default:           divLimit = psc_pkg::CNT_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [psc_pkg::SHIFT_W-1:0]    shift;
    logic                           sClkPrev;
    logic                           oscPrev;
    logic [psc_pkg::LOOP_W-1:0]     loopDiv;
    logic [psc_pkg::ODIV_W-1:0]     outDiv;
    logic [psc_pkg::DIAG_W-1:0]     diagSel;
    logic [psc_pkg::ODIV_CNT_W-1:0] divCnt;
    logic                           divClk;
    logic                           gate;
    logic                           synth;
    logic                           pllRef;
    logic                           diag;
  } psc_state_type;

  psc_state_type st_reg;
  psc_state_type st_next;

  localparam psc_state_type ST_RESET = '{
    shift:    '0,
    sClkPrev: 1'b0,
    oscPrev:  1'b0,
    loopDiv:  psc_pkg::LOOP_RESET,
    outDiv:   psc_pkg::ODIV_RESET,
    diagSel:  psc_pkg::DIAG_RESET,
    divCnt:   psc_pkg::CNT_ZERO,
    divClk:   1'b0,
    gate:     1'b0,
    synth:    1'b0,
    pllRef:   1'b0,
    diag:     1'b0
  };

  logic oscRise;
  logic cycleEnd;
  logic divToggle;
  logic byOne;

  always_comb
  begin
    st_next = st_reg;
    oscRise = oscIn && !st_reg.oscPrev;
    byOne = (st_reg.outDiv == psc_pkg::ODIV_BY1);
    cycleEnd = 1'b0;
    divToggle = 1'b0;
    st_next.sClkPrev = sClk;
    st_next.oscPrev = oscIn;
    if (sClk && !st_reg.sClkPrev)
    begin
      st_next.shift = {st_reg.shift[psc_pkg::SHIFT_W-2:0], sData};
    end
    if (sLoad)
    begin
      st_next.loopDiv = st_reg.shift[psc_pkg::LOOP_LSB +: psc_pkg::LOOP_W];
      st_next.outDiv = st_reg.shift[psc_pkg::ODIV_LSB +: psc_pkg::ODIV_W];
      st_next.diagSel = st_reg.shift[psc_pkg::DIAG_LSB +: psc_pkg::DIAG_W];
    end
    if (!pLoadB)
    begin
      st_next.loopDiv = pLoop;
      st_next.outDiv = pDiv;
    end
    if (oscRise)
    begin
      if (st_reg.divCnt >= divLimit(st_reg.outDiv))
      begin
        st_next.divCnt = psc_pkg::CNT_ZERO;
        divToggle = 1'b1;
      end
      else
      begin
        st_next.divCnt = st_reg.divCnt + 3'h1;
      end
    end
    if (byOne)
    begin
      st_next.divClk = oscIn;
      cycleEnd = !oscIn;
    end
    else if (divToggle)
    begin
      st_next.divClk = !st_reg.divClk;
      cycleEnd = st_reg.divClk;
    end
    if (cycleEnd || !st_next.divClk)
    begin
      st_next.gate = gateIn;
    end
    st_next.synth = st_next.divClk && st_next.gate;
    st_next.pllRef = srcSel ? xtalIn : extIn;
    case (st_reg.diagSel)
      3'h0:    st_next.diag = st_reg.divClk;
      3'h1:    st_next.diag = st_reg.pllRef;
      3'h2:    st_next.diag = oscIn;
      3'h3:    st_next.diag = sClk;
      3'h4:    st_next.diag = st_reg.shift[psc_pkg::SHIFT_W-1];
      3'h5:    st_next.diag = st_reg.gate;
      3'h6:    st_next.diag = 1'b1;
      default: st_next.diag = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= ST_RESET;
    end
    else if (clkEn)
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.

  assign loopDivOut = st_reg.loopDiv;
  assign outDivOut = st_reg.outDiv;
  assign diagSelOut = st_reg.diagSel;
  assign pllRefOut = st_reg.pllRef;
  assign synthClkOut = st_reg.synth;
  assign diagOut = st_reg.diag;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on serial and parallel loading and on the freeze while clock enable is low.

  a_serial_shift_in: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && sClk && !st_reg.sClkPrev |=> st_reg.shift[0] == $past(sData))
    else $error("serial bit not shifted in");

  a_serial_latch_follow: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && sLoad && pLoadB
      |=> loopDivOut == $past(st_reg.shift[psc_pkg::LOOP_LSB +: psc_pkg::LOOP_W]))
    else $error("loop divider does not follow shift register");

  a_latch_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && !sLoad && pLoadB |=> $stable(loopDivOut) && $stable(outDivOut))
    else $error("latches changed while both strobes closed");

  a_parallel_loop_take: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && !pLoadB |=> loopDivOut == $past(pLoop))
    else $error("loop divider does not follow parallel pins");

  a_parallel_div_take: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && !pLoadB |=> outDivOut == $past(pDiv))
    else $error("output divider does not follow parallel pins");

  a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !clkEn |=> $stable(st_reg))
    else $error("state changed while clock enable low");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the output divider and the output gate.

  a_div_count_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && oscRise |=> st_reg.divCnt <= divLimit($past(st_reg.outDiv)))
    else $error("divider count beyond limit");

  a_div_by_two: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && oscRise && st_reg.outDiv == psc_pkg::ODIV_BY2 |=> st_reg.divClk != $past(st_reg.divClk))
    else $error("divide by two misses a toggle");

  a_div_by_four: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && oscRise && st_reg.outDiv == psc_pkg::ODIV_BY4 && st_reg.divCnt == psc_pkg::CNT_ZERO
      |=> $stable(st_reg.divClk))
    else $error("divide by four toggles too early");

  a_div_by_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && byOne |=> st_reg.divClk == $past(oscIn))
    else $error("divide by one does not pass the oscillator");

  a_gate_blocks_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !st_reg.gate |-> !synthClkOut)
    else $error("output active while gated off");

  a_gate_no_runt: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && st_reg.divClk && !cycleEnd |=> st_reg.gate == $past(st_reg.gate))
    else $error("gate changed inside a high phase");

  a_gate_whole_rise: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(synthClkOut) |-> $rose(st_reg.divClk))
    else $error("output rose inside a divided high phase");

  a_gate_whole_fall: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(synthClkOut) |-> $fell(st_reg.divClk))
    else $error("output high phase cut short");

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on reference and diagnostic selection.

  a_ref_source_mux: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn |=> pllRefOut == ($past(srcSel) ? $past(xtalIn) : $past(extIn)))
    else $error("wrong reference source");

  a_diag_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && st_reg.diagSel == 3'h6 |=> diagOut)
    else $error("diagnostic select not honoured");

  a_diag_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && st_reg.diagSel == 3'h7 |=> !diagOut)
    else $error("diagnostic output not held low");

  a_diag_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clkEn && st_reg.diagSel == 3'h5 |=> diagOut == $past(st_reg.gate))
    else $error("diagnostic output does not show the gate");
endmodule

// [psc_host.sv]
// Host model that drives the serial configuration pins.
`timescale 1ns/1ns
module psc_host (
  input  wire logic ref_clk,
  output logic      serialClkIn,
  output logic      serialDataIn,
  output logic      serialLoadIn
);
  initial
  begin
    serialClkIn = 1'b0;
    serialDataIn = 1'b0;
    serialLoadIn = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Sends diagnostic, divider and loop fields, top bit first.
  task automatic shiftFrame(input logic [13:0] f);
    for (int i = 13; i >= 0; i--)
    begin
      serialDataIn = f[i];
      wt(6);
      serialClkIn = 1'b1;
      wt(6);
      serialClkIn = 1'b0;
      wt(6);
    end
    serialDataIn = 1'b0;
  endtask
  // Pulses the strobe while the shift register stands still.
  task automatic latchFrame();
    serialLoadIn = 1'b1;
    wt(8);
    serialLoadIn = 1'b0;
    wt(8);
  endtask
endmodule

// [psc_config_tb.sv]
// Self-checking testbench of the synthesizer configuration logic.
`timescale 1ns/1ns
module psc_config_tb;
  logic       ref_clk, rst_b, clkEn, parLoadBIn, outGateIn, ref_source_select;
  logic       xtalRefIn, external_ref_in, oscClkIn, pllRefOut, synthClkOut;
  logic       diagOut, serialClkIn, serialDataIn, serialLoadIn;
  logic [8:0] loopDivIn, loopDivOut;
  logic [1:0] outDivIn, outDivOut;
  logic [2:0] diagSelOut;
  int         nErrors, numChecks, per;
  psc_config i_dut (.ref_clk, .rst_b, .clkEn, .serialClkIn, .serialDataIn,
    .serialLoadIn, .parLoadBIn, .loopDivIn, .outDivIn, .outGateIn, .ref_source_select,
    .xtalRefIn, .external_ref_in, .oscClkIn, .loopDivOut, .outDivOut, .diagSelOut,
    .pllRefOut, .synthClkOut, .diagOut);
  psc_host i_host (.ref_clk, .serialClkIn, .serialDataIn, .serialLoadIn);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    oscClkIn = 1'b0;
    forever
    begin
      repeat (4) @(posedge ref_clk);
      #2 oscClkIn = ~oscClkIn;
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string m);
    numChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Counts cycles between two rising edges of the output clock.
  task automatic measPer(output int n);
    int r;
    logic pv;
    n = 0;
    r = 0;
    pv = synthClkOut;
    for (int k = 0; k < 400 && r < 2; k++)
    begin
      @(negedge ref_clk);
      if (r == 1)
        n++;
      if (synthClkOut === 1'b1 && pv === 1'b0)
        r++;
      pv = synthClkOut;
    end
    if (r < 2)
    begin
      chk(16'h0, 16'h1, "output clock timeout");
      endOfTest();
    end
  endtask
  task automatic loadPar(input logic [8:0] l, input logic [1:0] d);
    wt(1);
    loopDivIn = l;
    outDivIn = d;
    parLoadBIn = 1'b0;
    wt(8);
    parLoadBIn = 1'b1;
    wt(8);
  endtask
  task automatic testReset();
    wt(10);
    chk(16'(loopDivOut), 16'h01ff, "reset loop");
    chk(16'(outDivOut), 16'h0003, "reset div");
    chk(16'(diagSelOut), 16'h0000, "reset diag");
    wt(2);
    rst_b = 1'b1;
    wt(4);
    $display("reset test done");
  endtask
  task automatic testParallel();
    loopDivIn = 9'h0a5;
    outDivIn = 2'h1;
    parLoadBIn = 1'b0;
    wt(8);
    chk(16'(loopDivOut), 16'h00a5, "par loop");
    chk(16'(outDivOut), 16'h0001, "par div");
    loopDivIn = 9'h15a;
    wt(8);
    chk(16'(loopDivOut), 16'h015a, "par follow");
    parLoadBIn = 1'b1;
    wt(8);
    loopDivIn = 9'h003;
    outDivIn = 2'h2;
    wt(8);
    chk(16'(loopDivOut), 16'h015a, "par hold loop");
    chk(16'(outDivOut), 16'h0001, "par hold div");
    $display("parallel test done");
  endtask
  task automatic testSerial();
    i_host.shiftFrame({3'h5, 2'h2, 9'h13c});
    chk(16'(loopDivOut), 16'h015a, "ser before strobe");
    i_host.latchFrame();
    chk(16'(loopDivOut), 16'h013c, "ser loop");
    chk(16'(outDivOut), 16'h0002, "ser div");
    chk(16'(diagSelOut), 16'h0005, "ser diag");
    i_host.shiftFrame({3'h2, 2'h1, 9'h0f0});
    chk(16'(loopDivOut), 16'h013c, "ser hold");
    $display("serial test done");
  endtask
  task automatic testRefSel();
    xtalRefIn = 1'b1;
    wt(8);
    chk(16'(pllRefOut), 16'h1, "xtal high");
    ref_source_select = 1'b0;
    wt(8);
    chk(16'(pllRefOut), 16'h0, "ext low");
    external_ref_in = 1'b1;
    wt(8);
    chk(16'(pllRefOut), 16'h1, "ext high");
    ref_source_select = 1'b1;
    xtalRefIn = 1'b0;
    wt(8);
    chk(16'(pllRefOut), 16'h0, "xtal low");
    $display("reference test done");
  endtask
  task automatic testDivide();
    logic [3:0] rt [4];
    rt = '{4'h2, 4'h4, 4'h8, 4'h1};
    for (int c = 0; c < 4; c++)
    begin
      loadPar(9'h0a5, 2'(c));
      measPer(per);
      measPer(per);
      chk(16'(per), 16'(rt[c]) * 16'h8, "divide");
    end
    $display("divide test done");
  endtask
  task automatic testGate();
    wt(1);
    outGateIn = 1'b0;
    wt(20);
    per = 0;
    repeat (40)
    begin
      @(negedge ref_clk);
      if (synthClkOut !== 1'b0)
        per++;
    end
    chk(16'(per), 16'h0, "gate off");
    wt(1);
    outGateIn = 1'b1;
    measPer(per);
    measPer(per);
    chk(16'(per), 16'h8, "gate on");
    $display("gate test done");
  endtask
  task automatic diagCase(input logic [2:0] c, input logic e);
    i_host.shiftFrame({c, 2'h3, 9'h0a5});
    i_host.latchFrame();
    chk(16'(diagOut), 16'(e), "diag");
  endtask
  task automatic testDiag();
    diagCase(3'h6, 1'b1);
    diagCase(3'h7, 1'b0);
    diagCase(3'h1, 1'b0);
    diagCase(3'h3, 1'b0);
    diagCase(3'h4, 1'b1);
    diagCase(3'h5, 1'b1);
    $display("diag test done");
  endtask
  task automatic testFreeze();
    clkEn = 1'b0;
    loadPar(9'h1c3, 2'h0);
    chk(16'(loopDivOut), 16'h00a5, "freeze loop");
    chk(16'(outDivOut), 16'h0003, "freeze div");
    clkEn = 1'b1;
    wt(8);
    chk(16'(loopDivOut), 16'h00a5, "thaw hold");
    loadPar(9'h1c3, 2'h0);
    chk(16'(loopDivOut), 16'h01c3, "thaw loop");
    chk(16'(outDivOut), 16'h0000, "thaw div");
    $display("freeze test done");
  endtask
  initial
  begin
    rst_b = 1'b0;
    clkEn = 1'b1;
    parLoadBIn = 1'b1;
    loopDivIn = 9'h1ff;
    outDivIn = 2'h3;
    outGateIn = 1'b1;
    ref_source_select = 1'b1;
    xtalRefIn = 1'b0;
    external_ref_in = 1'b0;
    nErrors = 0;
    numChecks = 0;
    testReset();
    testParallel();
    testSerial();
    testRefSel();
    testDivide();
    testGate();
    testDiag();
    testFreeze();
    endOfTest();
  end
endmodule
